// ### rtl/kms_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the keypad matrix scanner.
// Assumes: Included by bare name; definitions only.
// Notes: Register and field definitions follow.
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH

`define KMS_ADDR_COL      8'hd1
`define KMS_ADDR_ROW      8'hd2
`define KMS_ADDR_SCAN     8'hd3
`define KMS_ADDR_STAT     8'hd4

`define KMS_RST_COL       5'h1f
`define KMS_RST_ROW       6'h3f
`define KMS_RST_SCAN      8'h00

`define KMS_BIT_IRQ_EN    0
`define KMS_BIT_DETECT    1
`define KMS_BIT_AUTO      2
`define KMS_BIT_TICK      3
`define KMS_DB_LSB        2
`define KMS_DB_STEP_MS    4
`define KMS_ROWS_HIGH     6'h3f

`endif

// ### rtl/kms_pkg.sv
// Purpose: Types of the keypad matrix scanner.
// Assumes: Nothing beyond the constants header.
// Notes: Scan states follow the press, scan, release sequence.
package kms_pkg;
	typedef enum logic [2:0] {
		KMS_IDLE,
		KMS_PRESS_DB,
		KMS_SCAN,
		KMS_WAIT_REL,
		KMS_REL_DB
	} kms_state_t;
endpackage : kms_pkg

// ### rtl/kms_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin levels.
// Assumes: Reset value given by parameter.
// Notes: Only the second stage is visible.
`timescale 1ns/100ps
`default_nettype none
module kms_sync #(
	parameter int         W   = 6,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : kms_sync
`default_nettype wire

// ### rtl/kms_scanner.sv
// Purpose: Keypad matrix scanner with debounce, single-key scan, bypass and detect interrupt.
// Assumes: Register port on mclk; 1 kHz tick and rows come from other domains.
// Notes: Debounce and step timing count whole tick rising edges.
`timescale 1ns/100ps
`default_nettype none
`include "kms_consts.svh"
module kms_scanner import kms_pkg::*; #(
	parameter int NROW = 6,
	parameter int NCOL = 5
) (
	input  wire logic            mclk,
	input  wire logic            arst_n,
	input  wire logic [7:0]      addr,
	input  wire logic [7:0]      wdata,
	input  wire logic            wr,
	input  wire logic            rd,
	output var  logic [7:0]      rdata,
	input  wire logic            key_tick,
	input  wire logic [NROW-1:0] row_in,
	output var  logic [NCOL-1:0] col_out,
	output var  logic            irq
);
	if (NROW != 6 || NCOL != 5) begin : g_bad_size
		$error("kms_scanner serves a 6 by 5 matrix only");
	end

	logic [NROW-1:0] row_s;
	logic            tick_s;
	logic            tick_d;
	logic            tick_rise;
	logic [NCOL-1:0] key_column_value;
	logic [NROW-1:0] key_row_value;
	logic [7:0]      scan_debounce_timing;
	logic            auto_scan_enable;
	logic            key_detect_flag;
	logic            key_detect_irq_enable;
	logic            rows_all_high_d;
	logic            bypass_fall;
	logic            auto_found;
	logic            stat_read;
	logic [8:0]      tmr;
	logic [2:0]      col_idx;
	logic [1:0]      hits;
	logic [NROW-1:0] hit_row;
	logic [NCOL-1:0] hit_col;
	logic [NCOL-1:0] col_drive;
	kms_state_t      state;
	logic [5:0]      debounce_period;
	logic [1:0]      column_step_time;
	logic [8:0]      db_ticks;
	logic [8:0]      step_ticks;
	logic            rows_any_low;
	logic            row_one_low;

	// Rows and tick arrive from pins and another clock.
	kms_sync #(.W(NROW), .RST(`KMS_RST_ROW)) u_row_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.d      (row_in),
		.q      (row_s)
	);
	kms_sync #(.W(1), .RST(1'b0)) u_tick_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.d      (key_tick),
		.q      (tick_s)
	);

	assign debounce_period  = scan_debounce_timing[7:`KMS_DB_LSB];
	assign column_step_time = scan_debounce_timing[1:0];
	// Code zero stands for 64 steps of 4 ms.
	assign db_ticks = (debounce_period == 6'h00) ? 9'd256 : {1'b0, debounce_period, 2'b00};
	always_comb begin
		case (column_step_time)
		2'b01:   step_ticks = 9'd1;
		2'b10:   step_ticks = 9'd2;
		2'b11:   step_ticks = 9'd3;
		default: step_ticks = 9'd4;
		endcase
	end
	assign rows_any_low = (row_s != `KMS_ROWS_HIGH);
	assign row_one_low  = ($countones(~row_s) == 1);
	assign tick_rise    = tick_s & ~tick_d;
	assign stat_read    = rd && (addr == `KMS_ADDR_STAT);
	// Bypass detection looks at rows only, so a stopped tick does not hide a press.
	assign bypass_fall  = !auto_scan_enable && rows_all_high_d && rows_any_low;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tick_d          <= 1'b0;
			rows_all_high_d <= 1'b1;
		end else begin
			tick_d          <= tick_s;
			rows_all_high_d <= !rows_any_low;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			scan_debounce_timing  <= `KMS_RST_SCAN;
			auto_scan_enable      <= 1'b0;
			key_detect_irq_enable <= 1'b0;
		end else if (wr) begin
			if (addr == `KMS_ADDR_SCAN)
				scan_debounce_timing <= wdata;
			if (addr == `KMS_ADDR_STAT) begin
				auto_scan_enable      <= wdata[`KMS_BIT_AUTO];
				key_detect_irq_enable <= wdata[`KMS_BIT_IRQ_EN];
			end
		end
	end

	// Set beats the clearing read so no key is lost.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			key_detect_flag <= 1'b0;
		else if (auto_found || bypass_fall)
			key_detect_flag <= 1'b1;
		else if (stat_read)
			key_detect_flag <= 1'b0;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= key_detect_irq_enable && (key_detect_flag || auto_found || bypass_fall)
				&& !(stat_read && !(auto_found || bypass_fall));
	end

	// Scan sequencer; advances only on tick edges.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state            <= KMS_IDLE;
			tmr              <= 9'd0;
			col_idx          <= 3'd0;
			hits             <= 2'd0;
			hit_row          <= `KMS_RST_ROW;
			hit_col          <= `KMS_RST_COL;
			auto_found       <= 1'b0;
		end else begin
			auto_found <= 1'b0;
			if (!auto_scan_enable) begin
				state <= KMS_IDLE;
			end else if (tick_rise) begin
				case (state)
				KMS_IDLE: begin
					if (rows_any_low) begin
						state <= KMS_PRESS_DB;
						tmr   <= 9'd1;
					end
				end
				KMS_PRESS_DB: begin
					if (tmr >= db_ticks) begin
						if (rows_any_low) begin
							state   <= KMS_SCAN;
							col_idx <= 3'd0;
							hits    <= 2'd0;
							tmr     <= 9'd0;
						end else begin
							state <= KMS_IDLE;
						end
					end else begin
						tmr <= tmr + 9'd1;
					end
				end
				KMS_SCAN: begin
					if (tmr + 9'd1 >= step_ticks) begin
						tmr <= 9'd0;
						if (rows_any_low) begin
							hits    <= (hits == 2'd0 && row_one_low) ? 2'd1 : 2'd2;
							hit_row <= row_s;
							hit_col <= col_drive;
						end
						if (col_idx == 3'(NCOL - 1)) begin
							state <= KMS_WAIT_REL;
							if ((hits == 2'd1 && !rows_any_low) ||
								(hits == 2'd0 && rows_any_low && row_one_low))
								auto_found <= 1'b1;
						end else begin
							col_idx <= col_idx + 3'd1;
						end
					end else begin
						tmr <= tmr + 9'd1;
					end
				end
				KMS_WAIT_REL: begin
					if (!rows_any_low) begin
						state <= KMS_REL_DB;
						tmr   <= 9'd1;
					end
				end
				KMS_REL_DB: begin
					if (rows_any_low)
						tmr <= 9'd1;
					else if (tmr >= db_ticks)
						state <= KMS_IDLE;
					else
						tmr <= tmr + 9'd1;
				end
				default: state <= KMS_IDLE;
				endcase
			end
		end
	end

	// Row register: live rows in bypass, latched valid key in automatic scan.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			key_row_value <= `KMS_RST_ROW;
		else if (!auto_scan_enable)
			key_row_value <= row_s;
		else if (auto_found)
			key_row_value <= (hits == 2'd1) ? hit_row : row_s;
	end

	// Column register keeps the last valid key, so a stop leaves that value on the pins.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			key_column_value <= `KMS_RST_COL;
		end else if (!auto_scan_enable) begin
			if (wr && addr == `KMS_ADDR_COL)
				key_column_value <= wdata[NCOL-1:0];
		end else if (auto_found) begin
			key_column_value <= hit_col;
		end
	end

	// All columns low while waiting, so keys still held after a scan keep the release wait going.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			col_drive <= '0;
		else if (state == KMS_SCAN)
			col_drive <= ~(5'(1) << col_idx);
		else
			col_drive <= '0;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			col_out <= `KMS_RST_COL;
		else
			col_out <= auto_scan_enable ? col_drive : key_column_value;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
				`KMS_ADDR_COL:  rdata <= {3'b000, key_column_value};
				`KMS_ADDR_ROW:  rdata <= {2'b00, key_row_value};
				`KMS_ADDR_SCAN: rdata <= scan_debounce_timing;
				`KMS_ADDR_STAT: rdata <= {4'h0, tick_s, auto_scan_enable,
						key_detect_flag, key_detect_irq_enable};
				default:        rdata <= 8'h00;
				endcase
			end
		end
	end

	a_flag_on_fall: assert property (@(posedge mclk) disable iff (!arst_n)
		bypass_fall |=> key_detect_flag) else $error("bypass fall did not set flag");
	a_read_clears: assert property (@(posedge mclk) disable iff (!arst_n)
		stat_read && !auto_found && !bypass_fall |=> !key_detect_flag) else $error("read left flag");
	a_irq_gated: assert property (@(posedge mclk) disable iff (!arst_n)
		!key_detect_irq_enable |=> !irq) else $error("irq while disabled");
	a_found_flag: assert property (@(posedge mclk) disable iff (!arst_n)
		auto_found |=> key_detect_flag) else $error("valid key did not set flag");
	a_bypass_rows: assert property (@(posedge mclk) disable iff (!arst_n)
		!auto_scan_enable ##1 !auto_scan_enable |-> key_row_value == $past(row_s))
		else $error("row register not live in bypass");
	a_col_follow: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> col_out == $past(auto_scan_enable ? col_drive : key_column_value))
		else $error("column pins lag");
	a_no_auto_off: assert property (@(posedge mclk) disable iff (!arst_n)
		!auto_scan_enable |=> state == KMS_IDLE) else $error("scan with auto off");
	a_tick_read: assert property (@(posedge mclk) disable iff (!arst_n)
		stat_read |=> rdata[`KMS_BIT_TICK] == $past(tick_s)) else $error("tick bit wrong");
	a_db_code0: assert property (@(posedge mclk) disable iff (!arst_n)
		debounce_period == 6'h00 && state == KMS_PRESS_DB && tmr < 9'd256 |=> state != KMS_SCAN)
		else $error("debounce zero code");
endmodule : kms_scanner
`default_nettype wire

// ### sim/kms_keypad_model.sv
// Purpose: Behavioural matrix of single-pole keypad switches.
// Assumes: Rows are pulled up; a closed key ties its row to its column.
// Notes: No bounce is modelled, so each press is one clean edge.
`timescale 1ns/100ps
`default_nettype none
module kms_keypad_model (
	input  wire logic [29:0] keys,
	input  wire logic [4:0]  col,
	output var  logic [5:0]  row
);
	always_comb begin
		for (int r = 0; r < 6; r++) begin
			row[r] = ~|(keys[r*5 +: 5] & ~col);
		end
	end
endmodule : kms_keypad_model
`default_nettype wire

// ### sim/keypad_matrix_scanner_bench.sv
// Purpose: Self-checking bench of the keypad matrix scanner.
// Assumes: Tick runs twenty clocks a period so debounce stays short.
// Notes: Step codes are judged by order of detection time.
`timescale 1ns/100ps
`default_nettype none
`include "kms_consts.svh"
module keypad_matrix_scanner_bench;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        key_tick = 1'b0;
	logic        tick_run = 1'b0;
	logic        tick_lvl = 1'b0;
	logic [29:0] keys = 30'h0;
	logic [7:0]  v;
	wire  [7:0]  rdata;
	wire  [5:0]  rows;
	wire  [4:0]  col_out;
	wire         irq;
	int          fail_count = 0;
	int          checked = 0;
	int          tcnt = 0;
	int          t[4];

	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		if (tick_run) begin
			tcnt <= (tcnt == 9) ? 0 : tcnt + 1;
			if (tcnt == 9) key_tick <= ~key_tick;
		end else begin
			key_tick <= tick_lvl;
		end
	end

	kms_scanner DUT (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .key_tick(key_tick), .row_in(rows), .col_out(col_out), .irq(irq));
	kms_keypad_model pad (.keys(keys), .col(col_out), .row(rows));

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, output logic [7:0] q);
		@(posedge mclk);
		addr <= a; rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask : rd_reg
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		rd_reg(a, q);
		chk(q, exp);
	endtask : rd_chk
	task wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk({7'h0, irq}, 8'h01);
	endtask : wait_irq

	task t_reset;
		rd_chk(`KMS_ADDR_ROW, 8'h3f);
		rd_chk(`KMS_ADDR_SCAN, 8'h00);
		rd_chk(`KMS_ADDR_STAT, 8'h00);
		wr_reg(8'hd0, 8'hff);
		rd_chk(8'hd0, 8'h00);
		@(posedge mclk) tick_lvl <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_chk(`KMS_ADDR_STAT, 8'h08);
		$display("reset and tick test done");
	endtask : t_reset
	task t_bypass;
		wr_reg(`KMS_ADDR_COL, 8'h1e);
		@(posedge mclk) tick_lvl <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({3'h0, col_out}, 8'h1e);
		keys <= 30'h2000000;
		repeat (6) @(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		rd_chk(`KMS_ADDR_ROW, 8'h1f);
		rd_chk(`KMS_ADDR_STAT, 8'h02);
		rd_chk(`KMS_ADDR_STAT, 8'h00);
		wr_reg(`KMS_ADDR_STAT, 8'h01);
		keys <= 30'h0;
		repeat (6) @(posedge mclk);
		keys <= 30'h2000000;
		repeat (6) @(posedge mclk);
		chk({7'h0, irq}, 8'h01);
		rd_chk(`KMS_ADDR_STAT, 8'h03);
		repeat (2) @(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		keys <= 30'h0;
		$display("bypass test done");
	endtask : t_bypass
	task t_auto;
		tick_run <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr_reg(`KMS_ADDR_SCAN, {6'h01, 2'((i + 1) % 4)});
			wr_reg(`KMS_ADDR_STAT, 8'h05);
			keys <= 30'h10;
			wait_irq(t[i]);
			rd_chk(`KMS_ADDR_ROW, 8'h3e);
			rd_chk(`KMS_ADDR_COL, 8'h0f);
			rd_reg(`KMS_ADDR_STAT, v);
			chk(v & 8'h07, 8'h07);
			if (i > 0) chk({7'h0, t[i] > t[i-1]}, 8'h01);
			keys <= 30'h0;
			repeat (300) @(posedge mclk);
			rd_chk(`KMS_ADDR_ROW, 8'h3e);
		end
		chk({7'h0, t[0] >= 80 && t[0] < 300}, 8'h01);
		$display("auto scan test done");
	endtask : t_auto
	task t_multi;
		keys <= 30'h40040;
		repeat (600) @(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		rd_chk(`KMS_ADDR_ROW, 8'h3e);
		rd_chk(`KMS_ADDR_COL, 8'h0f);
		chk({3'h0, col_out}, 8'h00);
		keys <= 30'h0;
		repeat (300) @(posedge mclk);
		keys <= 30'h10;
		wait_irq(t[0]);
		rd_reg(`KMS_ADDR_STAT, v);
		keys <= 30'h0;
		wr_reg(`KMS_ADDR_STAT, 8'h00);
		repeat (3) @(posedge mclk);
		chk({3'h0, col_out}, 8'h0f);
		$display("multi key test done");
	endtask : t_multi

	task print_verdict;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset;
		t_bypass;
		t_auto;
		t_multi;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		print_verdict;
	end
endmodule : keypad_matrix_scanner_bench
`default_nettype wire
